// [cer_defines.svh]
`ifndef CER_DEFINES_SVH
`define CER_DEFINES_SVH
// block sizes
`define CER_KIND_SMALL 2'h0
`define CER_KIND_MEDIUM 2'h1
`define CER_KIND_LARGE 2'h2
// data bits without parity per size
`define CER_SMALL_DATA_BITS 512
`define CER_MEDIUM_DATA_BITS 4096
`define CER_LARGE_DATA_BITS 524288
// register byte offsets
`define CER_CTRL_OFS 8'h00
`define CER_STAT_OFS 8'h04
// control fields
`define CER_CTRL_MODE_LSB 0
`define CER_CTRL_MODE_MSB 4
`define CER_CTRL_OREG_BIT 8
`define CER_CTRL_FT_BIT 9
`define CER_CTRL_OLD_BIT 10
// control reset values
`define CER_CTRL_MODE_RST 5'h01
`define CER_CTRL_OREG_RST 1'h1
`define CER_CTRL_FT_RST 1'h0
`define CER_CTRL_OLD_RST 1'h1
// status fields
`define CER_STAT_RDW_BIT 0
`define CER_STAT_WW_BIT 1
`define CER_STAT_BAD_BIT 2
`define CER_STAT_KIND_LSB 4
`define CER_STAT_KIND_MSB 5
// value returned for undefined read bits
`define CER_UNK_FILL 1'h0
`endif

// [cer_pkg.sv]
`default_nettype none
package cer_pkg;
   typedef enum logic [4:0] {
      mode_tdp = 5'h01,
      mode_sdp = 5'h02,
      mode_sp = 5'h04,
      mode_split = 5'h08,
      mode_rom = 5'h10
   } cer_mode_type;
endpackage
`default_nettype wire

// [cer_ram.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cer_defines.svh"
// Notes on behaviour
// - true dual-port: two independent ports may each read or write simultaneously
// - small size has no true dual-port; that request runs as simple dual-port
// - simple dual-port: read and write together; collision gives old or undefined
// - single-port: after a write the output shows the written word
// - all port inputs pass input registers; writes are synchronous
// - output register optional; bypass delivers read data one stage earlier
// - flow-through (simple dual-port, small and medium only): read address and enable taken on falling edge, output bypassed
// - one parity bit per byte stored and returned as plain data
// - medium and large sizes keep bytes whose write enable is low
// - ports may differ in width over one shared storage
// - small shapes from 512x1 to 32x18, parity included in x9 and x18
// - medium shapes 4Kx1 to 128x36; large shapes 64Kx8 to 4Kx144
// - outputs power up cleared; large outputs undefined, shown as fill
// - clear resets input and output registers; large resets outputs only
// - cross-port read during write: old or undefined; large always undefined
// - medium size may host two single-port memories of half size each
// - preload at start for small and medium, none for large
module cer_ram
   import cer_pkg::*;
#(
   parameter logic [1:0] KIND = `CER_KIND_MEDIUM,
   parameter int A_W = 36,
   parameter int B_W = 36,
   parameter logic [8:0] INIT_LANE = 9'h000
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [$clog2((((A_W % 9) == 0) ? (((KIND == `CER_KIND_SMALL) ? `CER_SMALL_DATA_BITS :
      (KIND == `CER_KIND_MEDIUM) ? `CER_MEDIUM_DATA_BITS : `CER_LARGE_DATA_BITS) / 8 * 9) :
      ((KIND == `CER_KIND_SMALL) ? `CER_SMALL_DATA_BITS : (KIND == `CER_KIND_MEDIUM) ?
      `CER_MEDIUM_DATA_BITS : `CER_LARGE_DATA_BITS)) / A_W)-1:0] a_addr,
   input wire logic [A_W-1:0] a_wdata,
   input wire logic a_we,
   input wire logic a_re,
   input wire logic [(A_W + (((A_W % 9) == 0) ? 9 : 8) - 1) / (((A_W % 9) == 0) ? 9 : 8)-1:0] a_be,
   output logic [A_W-1:0] a_rdata,
   input wire logic [$clog2((((B_W % 9) == 0) ? (((KIND == `CER_KIND_SMALL) ? `CER_SMALL_DATA_BITS :
      (KIND == `CER_KIND_MEDIUM) ? `CER_MEDIUM_DATA_BITS : `CER_LARGE_DATA_BITS) / 8 * 9) :
      ((KIND == `CER_KIND_SMALL) ? `CER_SMALL_DATA_BITS : (KIND == `CER_KIND_MEDIUM) ?
      `CER_MEDIUM_DATA_BITS : `CER_LARGE_DATA_BITS)) / B_W)-1:0] b_addr,
   input wire logic [B_W-1:0] b_wdata,
   input wire logic b_we,
   input wire logic b_re,
   input wire logic [(B_W + (((B_W % 9) == 0) ? 9 : 8) - 1) / (((B_W % 9) == 0) ? 9 : 8)-1:0] b_be,
   output logic [B_W-1:0] b_rdata,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // storage geometry per size and port shape
   localparam int DATA_BITS = (KIND == `CER_KIND_SMALL) ? `CER_SMALL_DATA_BITS :
      (KIND == `CER_KIND_MEDIUM) ? `CER_MEDIUM_DATA_BITS : `CER_LARGE_DATA_BITS;
   localparam int TOT_BITS = DATA_BITS / 8 * 9;
   localparam int A_LANE = ((A_W % 9) == 0) ? 9 : 8;
   localparam int B_LANE = ((B_W % 9) == 0) ? 9 : 8;
   localparam int A_DEPTH = ((A_LANE == 9) ? TOT_BITS : DATA_BITS) / A_W;
   localparam int B_DEPTH = ((B_LANE == 9) ? TOT_BITS : DATA_BITS) / B_W;
   localparam int A_AW = $clog2(A_DEPTH);
   localparam int B_AW = $clog2(B_DEPTH);
   localparam int A_NBE = (A_W + A_LANE - 1) / A_LANE;
   localparam int B_NBE = (B_W + B_LANE - 1) / B_LANE;
   localparam int A_L0 = (A_W < A_LANE) ? A_W : A_LANE;

   typedef struct packed {
      logic [A_AW-1:0] a_addr;
      logic [A_W-1:0] a_data;
      logic a_we;
      logic a_re;
      logic [A_NBE-1:0] a_be;
      logic [B_AW-1:0] b_addr;
      logic [B_W-1:0] b_data;
      logic b_we;
      logic b_re;
      logic [B_NBE-1:0] b_be;
   } cer_in_type;

   typedef struct packed {
      logic [A_W-1:0] a_lat;
      logic [A_W-1:0] a_rdata;
      logic [B_W-1:0] b_lat;
      logic [B_W-1:0] b_rdata;
      logic [4:0] mode;
      logic oreg;
      logic ft;
      logic old;
      logic rdw;
      logic ww;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } cer_state_type;

   localparam cer_state_type ST_RST = '{mode: `CER_CTRL_MODE_RST, oreg: `CER_CTRL_OREG_RST,
      ft: `CER_CTRL_FT_RST, old: `CER_CTRL_OLD_RST, default: '0};

   cer_in_type in_d;
   cer_in_type in_q;
   cer_state_type st_d;
   cer_state_type st_q;
   logic [B_AW-1:0] ft_addr_q;
   logic ft_re_q;
   cer_mode_type mode_eff;
   logic ft_eff;
   logic [A_AW-1:0] a_addr_eff;
   logic [B_AW-1:0] b_addr_eff;
   logic [A_NBE-1:0] a_be_eff;
   logic [B_NBE-1:0] b_be_eff;
   logic a_wr;
   logic a_rd;
   logic b_wr;
   logic b_rd;
   int unsigned a_base;
   int unsigned b_base;
   logic ov;
   logic a_coll;
   logic b_coll;
   logic ww_evt;
   logic unk_ok;
   logic [A_W-1:0] a_old;
   logic [A_W-1:0] a_new;
   logic [A_W-1:0] a_rv;
   logic [B_W-1:0] b_old;
   logic [B_W-1:0] b_new;
   logic [B_W-1:0] b_rv;
   logic acc;
   logic wr_done;
   logic hit_ctrl;
   logic hit_stat;

   // shared storage, parity lanes included
   logic [TOT_BITS-1:0] mem = {(TOT_BITS / 9){(KIND == `CER_KIND_LARGE) ? 9'h000 : INIT_LANE}};

   // input registers
   assign in_d = {a_addr, a_wdata, a_we, a_re, a_be, b_addr, b_wdata, b_we, b_re, b_be};
   generate
      if (KIND == `CER_KIND_LARGE)
      begin : g_in_keep
         always_ff @(posedge mclk)
         begin
            in_q <= in_d;
         end
      end
      else
      begin : g_in_clr
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
            begin
               in_q <= '0;
            end
            else
            begin
               in_q <= in_d;
            end
         end
      end
   endgenerate

   // falling-edge capture of read address for flow-through
   always_ff @(negedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ft_addr_q <= '0;
         ft_re_q <= 1'h0;
      end
      else
      begin
         ft_addr_q <= b_addr;
         ft_re_q <= b_re;
      end
   end

   // effective mode per size
   always_comb
   begin
      unique case (st_q.mode)
         mode_tdp: mode_eff = (KIND == `CER_KIND_SMALL) ? mode_sdp : mode_tdp;
         mode_sdp: mode_eff = mode_sdp;
         mode_sp: mode_eff = mode_sp;
         mode_split: mode_eff = (KIND == `CER_KIND_MEDIUM) ? mode_split : mode_sp;
         mode_rom: mode_eff = mode_rom;
         default: mode_eff = mode_sp;
      endcase
   end

   // port roles per mode
   always_comb
   begin
      ft_eff = st_q.ft && (mode_eff == mode_sdp) && (KIND != `CER_KIND_LARGE);
      a_addr_eff = in_q.a_addr;
      b_addr_eff = ft_eff ? ft_addr_q : in_q.b_addr;
      if (mode_eff == mode_split)
      begin
         a_addr_eff[A_AW-1] = 1'h0;
         b_addr_eff[B_AW-1] = 1'h1;
      end
      a_be_eff = (KIND == `CER_KIND_SMALL) ? '1 : in_q.a_be;
      b_be_eff = (KIND == `CER_KIND_SMALL) ? '1 : in_q.b_be;
      a_wr = in_q.a_we && (mode_eff != mode_rom);
      a_rd = (mode_eff == mode_sdp) ? 1'h0 : (in_q.a_re || a_wr);
      b_wr = in_q.b_we && ((mode_eff == mode_tdp) || (mode_eff == mode_split));
      b_rd = (mode_eff == mode_sdp) ? (ft_eff ? ft_re_q : in_q.b_re) :
         (mode_eff == mode_sp) ? 1'h0 : (in_q.b_re || b_wr);
   end

   // bit addressing over shared storage
   always_comb
   begin
      a_base = a_addr_eff * A_W;
      b_base = b_addr_eff * B_W;
      ov = (a_base < (b_base + B_W)) && (b_base < (a_base + A_W));
      a_old = mem[a_base +: A_W];
      b_old = mem[b_base +: B_W];
      for (int i = 0; i < A_W; i++)
      begin
         a_new[i] = a_be_eff[i / A_LANE] ? in_q.a_data[i] : a_old[i];
      end
      for (int j = 0; j < B_W; j++)
      begin
         b_new[j] = b_be_eff[j / B_LANE] ? in_q.b_data[j] : b_old[j];
      end
      a_coll = a_rd && !a_wr && b_wr && ov;
      b_coll = b_rd && !b_wr && a_wr && ov;
      ww_evt = a_wr && b_wr && ov;
      unk_ok = !st_q.old || (KIND == `CER_KIND_LARGE);
      a_rv = a_wr ? a_new : (a_coll && unk_ok) ? {A_W{`CER_UNK_FILL}} : a_old;
      b_rv = b_wr ? b_new : (b_coll && unk_ok) ? {B_W{`CER_UNK_FILL}} : b_old;
   end

   // array write strobe, port b last
   always_ff @(posedge mclk)
   begin
      if (a_wr)
      begin
         mem[a_base +: A_W] <= a_new;
      end
      if (b_wr)
      begin
         mem[b_base +: B_W] <= b_new;
      end
   end

   // read path and register file
   always_comb
   begin
      st_d = st_q;
      if (a_rd)
      begin
         st_d.a_lat = a_rv;
      end
      if (b_rd)
      begin
         st_d.b_lat = b_rv;
      end
      st_d.a_rdata = st_q.oreg ? st_q.a_lat : st_d.a_lat;
      st_d.b_rdata = (st_q.oreg && !ft_eff) ? st_q.b_lat : st_d.b_lat;
      acc = psel && penable && !st_q.pready;
      wr_done = psel && penable && st_q.pready && pwrite;
      hit_ctrl = paddr == `CER_CTRL_OFS;
      hit_stat = paddr == `CER_STAT_OFS;
      st_d.pready = acc;
      st_d.pslverr = acc && !hit_ctrl && !hit_stat;
      st_d.prdata = '0;
      if (acc && !pwrite && hit_ctrl)
      begin
         st_d.prdata[`CER_CTRL_MODE_MSB:`CER_CTRL_MODE_LSB] = st_q.mode;
         st_d.prdata[`CER_CTRL_OREG_BIT] = st_q.oreg;
         st_d.prdata[`CER_CTRL_FT_BIT] = st_q.ft;
         st_d.prdata[`CER_CTRL_OLD_BIT] = st_q.old;
      end
      if (acc && !pwrite && hit_stat)
      begin
         st_d.prdata[`CER_STAT_RDW_BIT] = st_q.rdw;
         st_d.prdata[`CER_STAT_WW_BIT] = st_q.ww;
         st_d.prdata[`CER_STAT_BAD_BIT] = st_q.mode != mode_eff;
         st_d.prdata[`CER_STAT_KIND_MSB:`CER_STAT_KIND_LSB] = KIND;
      end
      if (wr_done && hit_ctrl)
      begin
         st_d.mode = pwdata[`CER_CTRL_MODE_MSB:`CER_CTRL_MODE_LSB];
         st_d.oreg = pwdata[`CER_CTRL_OREG_BIT];
         st_d.ft = pwdata[`CER_CTRL_FT_BIT];
         st_d.old = pwdata[`CER_CTRL_OLD_BIT];
      end
      st_d.rdw = (st_q.rdw && !(wr_done && hit_stat && pwdata[`CER_STAT_RDW_BIT])) || a_coll || b_coll;
      st_d.ww = (st_q.ww && !(wr_done && hit_stat && pwdata[`CER_STAT_WW_BIT])) || ww_evt;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         st_q <= ST_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign a_rdata = st_q.a_rdata;
   assign b_rdata = st_q.b_rdata;
   assign prdata = st_q.prdata;
   assign pready = st_q.pready;
   assign pslverr = st_q.pslverr;

   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_input_capture: assert property (a_wr |-> $past(a_we))
      else $error("write strobe without registered write enable");
   a_small_no_tdp: assert property ((KIND == `CER_KIND_SMALL) |-> !b_wr)
      else $error("small block wrote through second port");
   a_rom_no_write: assert property ((mode_eff == mode_rom) |-> !a_wr && !b_wr)
      else $error("write while in rom mode");
   a_sp_write_shows: assert property (((mode_eff == mode_sp) || (mode_eff == mode_split)) && a_wr
      && !st_q.oreg && (&a_be_eff) |=> a_rdata == $past(in_q.a_data))
      else $error("single-port write not shown on output");
   a_oreg_two: assert property (a_wr && a_rd && st_q.oreg && (&a_be_eff) ##1 st_q.oreg
      |=> a_rdata == $past(in_q.a_data, 2))
      else $error("registered output latency wrong");
   a_ft_bypass: assert property (ft_eff |=> b_rdata == st_q.b_lat)
      else $error("flow-through output not bypassed");
   a_coll_sticky: assert property ((a_coll || b_coll) |=> st_q.rdw)
      else $error("collision flag not set");
   a_large_unknown: assert property ((KIND == `CER_KIND_LARGE) && a_coll
      |=> st_q.a_lat == {A_W{`CER_UNK_FILL}})
      else $error("large block returned data on collision");
   a_split_half: assert property ((mode_eff == mode_split) |-> !a_addr_eff[A_AW-1] && b_addr_eff[B_AW-1])
      else $error("split halves overlap");
   a_byte_keep: assert property ((KIND != `CER_KIND_SMALL) && a_wr && !b_wr && !a_be_eff[0]
      |=> mem[$past(a_base) +: A_L0] == $past(mem[a_base +: A_L0]))
      else $error("masked byte changed");

   c_tdp_two_writes: cover property ((mode_eff == mode_tdp) && a_wr && b_wr);
   c_sp_write_read: cover property (a_wr ##1 a_rd && !a_wr);
   c_ft_read: cover property (ft_eff && b_rd);
   c_collision: cover property (a_coll || b_coll);

endmodule
`default_nettype wire

// [cer_user.sv]
`timescale 1ns/10ps
`default_nettype none
module cer_user
(
   input wire logic mclk,
   output logic [6:0] a_addr,
   output logic [35:0] a_wdata,
   output logic a_we,
   output logic a_re,
   output logic [3:0] a_be,
   output logic [6:0] b_addr,
   output logic [35:0] b_wdata,
   output logic b_we,
   output logic b_re,
   output logic [3:0] b_be
);
   initial
   begin
      {a_we, a_re, a_addr, a_wdata, a_be} = '0;
      {b_we, b_re, b_addr, b_wdata, b_be} = '0;
   end
   // request on one port, held until the next put or idle call
   task automatic put(input logic p, input logic we, input logic re, input logic [6:0] ad,
      input logic [35:0] d, input logic [3:0] be);
      if (!p)
         {a_we, a_re, a_addr, a_wdata, a_be} <= {we, re, ad, d, be};
      else
         {b_we, b_re, b_addr, b_wdata, b_be} <= {we, re, ad, d, be};
   endtask
   // released address and data lines show the inverse of their last value; read and write enables go low
   task automatic idle();
      {a_we, a_re, a_addr, a_wdata} <= {2'b00, ~a_addr, ~a_wdata};
      {b_we, b_re, b_addr, b_wdata} <= {2'b00, ~b_addr, ~b_wdata};
   endtask
   // callers never write one word from both ports at once
endmodule
`default_nettype wire

// [tb_configurable_embedded_ram.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_configurable_embedded_ram
   import cer_pkg::*;
;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [6:0] a_addr, b_addr, ad;
   logic [35:0] a_wdata, b_wdata, a_rdata, b_rdata, d, last_b;
   logic a_we, a_re, b_we, b_re;
   logic [3:0] a_be, b_be, be;
   logic [35:0] mem [128];
   int num_errors, checks_done, cycles;

   cer_user u (.mclk, .a_addr, .a_wdata, .a_we, .a_re, .a_be, .b_addr, .b_wdata, .b_we, .b_re, .b_be);
   cer_ram #(.KIND(2'h1), .A_W(36), .B_W(36), .INIT_LANE(9'h0A5)) DUT (.mclk, .rst, .a_addr, .a_wdata,
      .a_we, .a_re, .a_be, .a_rdata, .b_addr, .b_wdata, .b_we, .b_re, .b_be, .b_rdata, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

   task automatic end_of_test();
      if (num_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // expected control word from its fields
   function automatic logic [31:0] ctrl_word(input logic [4:0] mode, input logic oreg, input logic ft,
      input logic old);
      return {21'h0, old, ft, oreg, 3'h0, mode};
   endfunction

   // expected status word of the medium instance
   function automatic logic [31:0] stat_word(input logic rdw, input logic ww);
      return {26'h0, 2'h1, 2'h0, ww, rdw};
   endfunction

   task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
      input logic [31:0] exp, input logic err);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, adr, wd};
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
      end
      while (pready !== 1'b1);
      if (!wr)
         check("prdata", 36'(prdata), 36'(exp));
      check("pslverr", 36'(pslverr), 36'(err));
      {psel, penable} <= 2'b00;
      @(posedge mclk);
   endtask

   // write on port a; shadow keeps untouched lanes
   task automatic wr_a(input logic [6:0] wa, input logic [35:0] wd, input logic [3:0] wb);
      u.put(1'b0, 1'b1, 1'b0, wa, wd, wb);
      @(posedge mclk);
      u.idle();
      for (int i = 0; i < 4; i++)
         if (wb[i])
            mem[wa][9*i +: 9] = wd[9*i +: 9];
      @(posedge mclk);
   endtask

   // read on port b, output checked one and two edges after capture
   task automatic rd_b(input logic [6:0] ra, input logic oreg);
      u.put(1'b1, 1'b0, 1'b1, ra, '0, 4'hF);
      @(posedge mclk);
      u.idle();
      @(posedge mclk);
      #1;
      check("b_rdata early", b_rdata, oreg ? last_b : mem[ra]);
      @(posedge mclk);
      #1;
      check("b_rdata", b_rdata, mem[ra]);
      last_b = mem[ra];
      @(posedge mclk);
   endtask

   initial
   begin
      mclk = 1'b0;
      forever
         #10 mclk = ~mclk;
   end

   initial
   begin
      cycles = 0;
      forever
      begin
         @(posedge mclk);
         cycles++;
         if (cycles > 5000)
         begin
            num_errors++;
            end_of_test();
         end
      end
   end

   initial
   begin
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      num_errors = 0;
      checks_done = 0;
      last_b = '0;
      foreach (mem[i])
         mem[i] = {4{9'h0A5}};
      void'($urandom(32'h498600C3));
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      check("a_rdata", a_rdata, '0);
      check("b_rdata", b_rdata, '0);
      @(posedge mclk);
      apb(1'b0, 8'h00, '0, ctrl_word(5'h01, 1'b1, 1'b0, 1'b1), 1'b0);
      apb(1'b0, 8'h04, '0, stat_word(1'b0, 1'b0), 1'b0);
      apb(1'b0, 8'h08, '0, 32'h00000000, 1'b1);
      rd_b(7'h7F, 1'b1);
      for (int i = 0; i < 12; i++)
      begin
         ad = 7'($urandom_range(63));
         d = {4'($urandom()), 32'($urandom())};
         be = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom());
         wr_a(ad, d, be);
         rd_b(ad, 1'b1);
      end
      // both ports write distinct words in one cycle
      ad = 7'($urandom_range(31));
      d = {4'($urandom()), 32'($urandom())};
      u.put(1'b0, 1'b1, 1'b0, ad, d, 4'hF);
      u.put(1'b1, 1'b1, 1'b0, ad | 7'h20, ~d, 4'hF);
      @(posedge mclk);
      u.idle();
      mem[ad] = d;
      mem[ad | 7'h20] = ~d;
      last_b = ~d;
      @(posedge mclk);
      rd_b(ad, 1'b1);
      rd_b(ad | 7'h20, 1'b1);
      apb(1'b1, 8'h00, 32'h00000401, '0, 1'b0);
      for (int i = 0; i < 4; i++)
         rd_b(7'($urandom_range(63)), 1'b0);
      // same word written on a and read on b in one cycle
      apb(1'b1, 8'h00, 32'h00000402, '0, 1'b0);
      ad = 7'h05;
      d = ~mem[ad];
      u.put(1'b0, 1'b1, 1'b0, ad, d, 4'hF);
      u.put(1'b1, 1'b0, 1'b1, ad, '0, 4'hF);
      @(posedge mclk);
      u.idle();
      @(posedge mclk);
      #1;
      check("b_rdata old", b_rdata, mem[ad]);
      last_b = mem[ad];
      mem[ad] = d;
      @(posedge mclk);
      rd_b(ad, 1'b0);
      apb(1'b0, 8'h04, '0, stat_word(1'b1, 1'b0), 1'b0);
      // flow-through read
      apb(1'b1, 8'h00, 32'h00000602, '0, 1'b0);
      ad = 7'($urandom_range(63));
      u.put(1'b1, 1'b0, 1'b1, ad, '0, 4'hF);
      @(posedge mclk);
      #1;
      check("b_rdata flow", b_rdata, mem[ad]);
      @(posedge mclk);
      u.idle();
      @(posedge mclk);
      // single-port write shows on output
      apb(1'b1, 8'h00, 32'h00000404, '0, 1'b0);
      d = {4'($urandom()), 32'($urandom())};
      wr_a(7'h11, d, 4'hF);
      #1;
      check("a_rdata through", a_rdata, mem[7'h11]);
      // rom use: contents written earlier, write enables stay low
      @(posedge mclk);
      apb(1'b1, 8'h00, 32'h00000410, '0, 1'b0);
      rd_b(7'h11, 1'b0);
      // two half-size memories: port b sees the upper half
      apb(1'b1, 8'h00, 32'h00000408, '0, 1'b0);
      d = {4'($urandom()), 32'($urandom())};
      wr_a(7'h03, d, 4'hF);
      u.put(1'b1, 1'b0, 1'b1, 7'h03, '0, 4'hF);
      @(posedge mclk);
      u.idle();
      @(posedge mclk);
      #1;
      check("b_rdata half", b_rdata, mem[7'h43]);
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      #1;
      check("a_rdata clr", a_rdata, '0);
      check("b_rdata clr", b_rdata, '0);
      @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      apb(1'b0, 8'h00, '0, ctrl_word(5'h01, 1'b1, 1'b0, 1'b1), 1'b0);
      apb(1'b0, 8'h04, '0, stat_word(1'b0, 1'b0), 1'b0);
      end_of_test();
   end
endmodule
`default_nettype wire
